// *** verilog/aoc_pkg.sv ***
`default_nettype none
package aoc_pkg;
  // ============================================================
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CONV = 8'h04;
  localparam logic [7:0] A_USE = 8'h08;
  localparam logic [7:0] A_RES = 8'h0C;
  localparam logic [7:0] A_STOP = 8'h10;
  localparam logic [7:0] A_BIP = 8'h14;
  localparam logic [7:0] A_ERR = 8'h18;
  localparam logic [7:0] A_RESTART = 8'h1C;
  localparam logic [7:0] A_SV = 8'h20;
  localparam logic [7:0] A_SCL = 8'h40;
  localparam logic [7:0] A_OUT = 8'h60;
  // ============================================================
  // field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FAULT = 1;
  localparam int CTRL_ADJ = 2;
  localparam int CTRL_ADJSEL = 4;
  localparam int ERR_SCL = 8;
  localparam int ERR_STOP = 9;
  localparam int ERR_MODE = 10;
  localparam int SCL_UPPER = 16;
  // ============================================================
  // encodings and reset values
  localparam logic [1:0] STOP_CLEAR = 2'h0;
  localparam logic [1:0] STOP_HOLD = 2'h1;
  localparam logic [1:0] STOP_MAX = 2'h2;
  localparam logic [7:0] RES_LONG = 8'h00;
  localparam logic [7:0] RES_SHORT = 8'hC1;
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [1:0] STOP_RST = 2'h0;
  // ============================================================
  // full scale, band and limits
  localparam int FS_LONG = 4000;
  localparam int FS_SHORT = 8000;
  localparam int BAND_DIV = 20;
  localparam int SCL_LIM = 32000;
  // ============================================================
  // timing
  localparam int CLK_KHZ = 20000;
  localparam int CYC_LONG_US = 1000;
  localparam int CYC_SHORT_US = 250;
  localparam int CYC_LONG_DEF = CYC_LONG_US * CLK_KHZ / 1000;
  localparam int CYC_SHORT_DEF = CYC_SHORT_US * CLK_KHZ / 1000;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DIV = 3'b010,
    S_CHK = 3'b100
  } aoc_state_e;
endpackage : aoc_pkg
`default_nettype wire

// *** verilog/aoc_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// unsigned restoring divider, one quotient bit per cycle
module aoc_div #(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [W-1:0] i_num,
  input wire logic [W-1:0] i_den,
  output logic o_done,
  output logic [W-1:0] o_quot
);
  // the 8-bit step counter bounds the width
  if (W < 2 || W > 255) begin : g_chk_w
    $error("divider width must lie between 2 and 255");
  end
  logic [W:0] rem_r;
  logic [W:0] trial_c;
  logic [W-1:0] den_r;
  logic [7:0] cnt_r;
  logic busy_r;
  assign trial_c = {rem_r[W-1:0], o_quot[W-1]} - {1'b0, den_r};
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rem_r <= '0;
      den_r <= '0;
      o_quot <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= busy_r && (cnt_r == 8'h01);
      if (i_start) begin
        rem_r <= '0;
        den_r <= i_den;
        o_quot <= i_num;
        cnt_r <= 8'(W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
        busy_r <= (cnt_r != 8'h01);
        if (!trial_c[W]) begin
          rem_r <= trial_c;
          o_quot <= {o_quot[W-2:0], 1'b1};
        end else begin
          rem_r <= {rem_r[W-1:0], o_quot[W-1]};
          o_quot <= {o_quot[W-2:0], 1'b0};
        end
      end
    end
  end
endmodule : aoc_div
`default_nettype wire

// *** verilog/aoc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - each output has its own conversion enable bit; converts only while set
// R2 - batch enable word, one bit per output, width follows output count
// R3 - eight outputs, or four or two on reduced variants
// R4 - no conversion under foreign adjustment, set-value error or major fault
// R5 - run to program mode or reset clears all enables, stop state applies
// R6 - any stopped output drives its selected stop-state value
// R7 - stop selector: 0 clear, 1 hold, 2 maximum
// R8 - clear drives -5% of full scale unipolar, zero bipolar
// R9 - maximum drives +5% above full scale
// R10 - hold keeps last converted value
// R11 - configured limits map set values linearly onto full scale
// R12 - scaling only in the 1 ms, 4000-step mode
// R13 - lower limit above upper gives reverse scaling
// R14 - out of -5..+105% band raises error and stops output
// R15 - equal limits or beyond 32000 flag scaling error, refuse operation
// R16 - both limits zero bypasses scaling
// R17 - per-output set-value error flag, 1 means invalid
// R18 - all set-value error flags readable as one byte
// R19 - stop-state and scaling setup load only at reset or restart
// R20 - unused outputs drive zero and are skipped in the sequence
// R21 - resolution 16#00 is 4000 steps 1 ms, 16#C1 8000 steps 250 us
// R22 - scaled code by interpolation rounded to nearest, then band check
module aoc_ctrl
  import aoc_pkg::*;
#(
  parameter int N_OUT = 8,
  parameter int CYC_LONG = CYC_LONG_DEF,
  parameter int CYC_SHORT = CYC_SHORT_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [N_OUT*16-1:0] o_out_code,
  output logic [N_OUT-1:0] o_conv_active,
  output logic [N_OUT-1:0] o_setvalue_err,
  output logic o_config_err
);
  localparam int IW = $clog2(N_OUT);
  localparam int P5L = FS_LONG / BAND_DIV;
  localparam int P5S = FS_SHORT / BAND_DIV;
  // ============================================================
  // elaboration checks
  if (!(N_OUT == 2 || N_OUT == 4 || N_OUT == 8)) begin : g_chk_n
    $error("N_OUT must be 2, 4 or 8"); // R3
  end
  if (CYC_LONG < 1 || CYC_LONG > 65535 || CYC_SHORT < 1 || CYC_SHORT > 65535) begin : g_chk_c
    $error("cycle counts out of range");
  end
  // ============================================================
  // register state
  logic run_r, fault_r, adj_r;
  logic [2:0] adj_sel_r;
  logic [N_OUT-1:0] conv_en_r, use_sh_r, use_r, bip_sh_r, bip_r, err_r;
  logic [7:0] res_sh_r, res_r;
  logic [2*N_OUT-1:0] stop_sh_r, stop_r;
  logic [31:0] scl_sh_r [N_OUT];
  logic [31:0] scl_r [N_OUT];
  logic signed [15:0] sv_r [N_OUT];
  logic signed [15:0] out_r [N_OUT];
  logic [N_OUT-1:0] conv_c, bypass_c, bad_c, stopbad_c;
  logic signed [15:0] clear_lvl_c [N_OUT];
  logic signed [15:0] max_c [N_OUT];
  logic [31:0] rd_c;
  logic miss_r, cfg_err_r;
  // ============================================================
  // apb decode; data registered in setup so access needs no wait
  logic setup_c, wr_c, hit_c, restart_c;
  logic [2:0] area_c;
  logic [IW-1:0] idx_c;
  assign setup_c = i_psel & ~i_penable;
  assign wr_c = i_psel & i_penable & i_pwrite;
  assign area_c = i_paddr[7:5];
  assign idx_c = i_paddr[IW+1:2];
  assign hit_c = (i_paddr[1:0] == 2'h0) && (area_c == 3'h0 ||
                 (area_c <= A_OUT[7:5] && int'(i_paddr[4:2]) < N_OUT));
  assign restart_c = wr_c && i_paddr == A_RESTART && i_pwdata[0];
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & miss_r;
  // ============================================================
  // host control and conversion enables
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      run_r <= 1'b0;
      fault_r <= 1'b0;
      adj_r <= 1'b0;
      adj_sel_r <= 3'h0;
    end else if (wr_c && i_paddr == A_CTRL) begin
      run_r <= i_pwdata[CTRL_RUN];
      fault_r <= i_pwdata[CTRL_FAULT];
      adj_r <= i_pwdata[CTRL_ADJ];
      adj_sel_r <= i_pwdata[CTRL_ADJSEL+:3];
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || restart_c) begin
      conv_en_r <= '0; // R5
    end else if (run_r && wr_c && i_paddr == A_CTRL && !i_pwdata[CTRL_RUN]) begin
      conv_en_r <= '0; // R5
    end else if (wr_c && i_paddr == A_CONV) begin
      conv_en_r <= i_pwdata[N_OUT-1:0]; // R1 R2
    end
  end
  // ============================================================
  // setup shadows, written any time, taken over only at restart
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      use_sh_r <= '1;
      bip_sh_r <= '0;
      res_sh_r <= RES_RST;
      stop_sh_r <= {N_OUT{STOP_RST}};
      for (int k = 0; k < N_OUT; k++) begin
        scl_sh_r[k] <= '0;
      end
    end else if (wr_c) begin
      if (i_paddr == A_USE) use_sh_r <= i_pwdata[N_OUT-1:0];
      if (i_paddr == A_BIP) bip_sh_r <= i_pwdata[N_OUT-1:0];
      if (i_paddr == A_RES) res_sh_r <= i_pwdata[7:0];
      if (i_paddr == A_STOP) stop_sh_r <= i_pwdata[2*N_OUT-1:0];
      if (hit_c && area_c == A_SCL[7:5]) scl_sh_r[idx_c] <= i_pwdata;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      use_r <= '1; // R19
      bip_r <= '0;
      res_r <= RES_RST;
      stop_r <= {N_OUT{STOP_RST}};
      for (int k = 0; k < N_OUT; k++) begin
        scl_r[k] <= '0;
      end
    end else if (restart_c) begin
      use_r <= use_sh_r; // R19
      bip_r <= bip_sh_r;
      res_r <= res_sh_r;
      stop_r <= stop_sh_r;
      scl_r <= scl_sh_r;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int k = 0; k < N_OUT; k++) begin
        sv_r[k] <= '0;
      end
    end else if (wr_c && hit_c && area_c == A_SV[7:5]) begin
      sv_r[idx_c] <= i_pwdata[15:0];
    end
  end
  // ============================================================
  // setup checks and per-output stop levels
  logic long_c, mode_err_c, refuse_c;
  logic signed [15:0] fs_c, p5_c;
  assign long_c = (res_r == RES_LONG); // R21
  assign mode_err_c = !long_c && res_r != RES_SHORT; // R21
  assign fs_c = long_c ? 16'(FS_LONG) : 16'(FS_SHORT);
  assign p5_c = long_c ? 16'(P5L) : 16'(P5S);
  assign refuse_c = (|bad_c) | (|stopbad_c) | mode_err_c;
  always_comb begin
    for (int k = 0; k < N_OUT; k++) begin
      bypass_c[k] = (scl_r[k] == 32'h0000_0000); // R16
      bad_c[k] = use_r[k] && !bypass_c[k] && ( // R15
                 scl_r[k][15:0] == scl_r[k][31:16] ||
                 $signed(scl_r[k][15:0]) > 16'sd32000 ||
                 $signed(scl_r[k][15:0]) < -16'sd32000 ||
                 $signed(scl_r[k][31:16]) > 16'sd32000 ||
                 $signed(scl_r[k][31:16]) < -16'sd32000);
      stopbad_c[k] = use_r[k] && stop_r[2*k+:2] > STOP_MAX; // R7
      clear_lvl_c[k] = bip_r[k] ? 16'sd0 : -p5_c; // R8
      max_c[k] = fs_c + (bip_r[k] ? 16'(2 * p5_c) : p5_c); // R9
      conv_c[k] = conv_en_r[k] && use_r[k] && !err_r[k] && !fault_r && // R1 R4
                  !(adj_r && int'(adj_sel_r) != k) && !refuse_c; // R4 R15
    end
  end
  // ============================================================
  // conversion sequencer: one used output per conversion tick
  aoc_state_e state_r;
  logic [IW-1:0] ch_r, nxt_c;
  logic found_c, go_c, tick_c, neg_r, dstart_c, ddone_c, inband_c;
  logic [15:0] cnt_r;
  logic signed [32:0] val_r, lo_c, hi_c;
  logic signed [17:0] d_c, dl_c;
  logic [31:0] num_c, den_c, quot_c;
  assign tick_c = (cnt_r == 16'h0000);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || tick_c) begin
      cnt_r <= long_c ? 16'(CYC_LONG - 1) : 16'(CYC_SHORT - 1); // R21
    end else begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  always_comb begin
    nxt_c = ch_r;
    found_c = 1'b0;
    for (int k = N_OUT; k >= 1; k--) begin
      if (use_r[IW'(int'(ch_r) + k)]) begin // R20
        nxt_c = IW'(int'(ch_r) + k);
        found_c = 1'b1;
      end
    end
  end
  assign go_c = state_r == S_IDLE && tick_c && found_c && !refuse_c;
  assign dstart_c = go_c && long_c && !bypass_c[nxt_c]; // R12 R16
  // lower limit maps to bottom, upper to top; signs give reverse scaling
  assign d_c = 18'(sv_r[nxt_c]) - 18'($signed(scl_r[nxt_c][15:0])); // R11
  assign dl_c = 18'($signed(scl_r[nxt_c][31:16])) - 18'($signed(scl_r[nxt_c][15:0]));
  assign den_c = 32'(dl_c[17] ? -dl_c : dl_c);
  assign num_c = 32'(d_c[17] ? -d_c : d_c) * 32'(bip_r[nxt_c] ? 2 * fs_c : fs_c)
                 + (den_c >> 1); // R22
  assign lo_c = bip_r[ch_r] ? -33'(fs_c) : 33'sd0;
  assign hi_c = 33'(fs_c);
  aoc_div #(.W(32)) u_div (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_start(dstart_c),
    .i_num(num_c),
    .i_den(den_c),
    .o_done(ddone_c),
    .o_quot(quot_c)
  );
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_r <= S_IDLE;
      ch_r <= '0;
      val_r <= '0;
      neg_r <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (go_c) begin
            ch_r <= nxt_c;
            neg_r <= d_c[17] ^ dl_c[17]; // R13
            val_r <= 33'(sv_r[nxt_c]);
            state_r <= dstart_c ? S_DIV : S_CHK; // R12
          end
        end
        S_DIV: begin
          if (ddone_c) begin
            val_r <= neg_r ? lo_c - $signed({1'b0, quot_c}) // R11 R13
                           : lo_c + $signed({1'b0, quot_c});
            state_r <= S_CHK;
          end
        end
        S_CHK: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end
  // band check after rounding, so edge codes land exactly on the limits
  assign inband_c = val_r >= lo_c - 33'(bip_r[ch_r] ? 2 * p5_c : p5_c) && // R14
                    val_r <= hi_c + 33'(bip_r[ch_r] ? 2 * p5_c : p5_c);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      err_r <= '0;
    end else if (state_r == S_CHK) begin
      err_r[ch_r] <= !inband_c; // R14 R17
    end
  end
  // ============================================================
  // output codes; hold keeps the register untouched
  always_ff @(posedge i_clk_sys) begin
    for (int k = 0; k < N_OUT; k++) begin
      if (i_sys_rst || !use_r[k]) begin
        out_r[k] <= '0; // R5 R20
      end else if (!conv_c[k]) begin
        case (stop_r[2*k+:2]) // R6 R7
          STOP_CLEAR: out_r[k] <= clear_lvl_c[k]; // R8
          STOP_MAX: out_r[k] <= max_c[k]; // R9
          default: out_r[k] <= out_r[k]; // R10
        endcase
      end else if (state_r == S_CHK && int'(ch_r) == k && inband_c) begin
        out_r[k] <= val_r[15:0]; // R1 R14
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_conv_active <= '0;
      cfg_err_r <= 1'b0;
    end else begin
      o_conv_active <= conv_c;
      cfg_err_r <= refuse_c; // R15
    end
  end
  always_comb begin
    for (int k = 0; k < N_OUT; k++) begin
      o_out_code[16*k+:16] = out_r[k];
    end
  end
  assign o_setvalue_err = err_r; // R17
  assign o_config_err = cfg_err_r;
  // ============================================================
  // read data
  always_comb begin
    rd_c = 32'h0000_0000;
    case (area_c)
      3'h0: begin
        case (i_paddr)
          A_CTRL: rd_c = 32'({adj_sel_r, 1'b0, adj_r, fault_r, run_r});
          A_CONV: rd_c = 32'(conv_en_r);
          A_USE: rd_c = 32'(use_sh_r);
          A_RES: rd_c = 32'(res_sh_r);
          A_STOP: rd_c = 32'(stop_sh_r);
          A_BIP: rd_c = 32'(bip_sh_r);
          A_ERR: rd_c = 32'({mode_err_c, |stopbad_c, |bad_c, 8'(err_r)}); // R18
          default: rd_c = 32'h0000_0000;
        endcase
      end
      3'h1: rd_c = 32'(sv_r[idx_c]);
      3'h2: rd_c = scl_sh_r[idx_c];
      3'h3: rd_c = 32'(out_r[idx_c]);
      default: rd_c = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_prdata <= '0;
      miss_r <= 1'b0;
    end else if (setup_c) begin
      o_prdata <= hit_c ? rd_c : 32'h0000_0000;
      miss_r <= !hit_c;
    end
  end
  // ============================================================
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_go_short;
    go_c && !long_c;
  endsequence
  sequence s_check;
    state_r == S_CHK;
  endsequence
  short_noscale_a: assert property (s_go_short |=> s_check) // R12
    else $error("short mode started a division");
  band_err_a: assert property (s_check and !inband_c |=> err_r[$past(ch_r)]) // R14
    else $error("out of band value left no error");
  run_drop_a: assert property ($fell(run_r) |-> conv_en_r == '0) // R5
    else $error("enables survived leaving run mode");
  fault_block_a: assert property (fault_r |=> o_conv_active == '0) // R4
    else $error("conversion active during major fault");
  unused_zero_a: assert property (!use_r[N_OUT-1] |=> out_r[N_OUT-1] == 16'sd0) // R20
    else $error("unused output not zero");
  clear_level_a: assert property (use_r[0] && !conv_c[0] && long_c && !bip_r[0] // R8
    && stop_r[1:0] == STOP_CLEAR |=> out_r[0] == -16'sd200)
    else $error("clear level wrong");
  max_level_a: assert property (use_r[0] && !conv_c[0] && long_c && !bip_r[0] // R9
    && stop_r[1:0] == STOP_MAX |=> out_r[0] == 16'sd4200)
    else $error("max level wrong");
  hold_keep_a: assert property (use_r[1] && !conv_c[1] // R10
    && stop_r[3:2] == STOP_HOLD |=> out_r[1] == $past(out_r[1]))
    else $error("hold level moved");
  cfg_freeze_a: assert property (!restart_c |=> $stable(stop_r) && $stable(scl_r[0])) // R19
    else $error("setup changed while running");
  batch_err_a: assert property (setup_c && i_paddr == A_ERR // R18
    |=> o_prdata[N_OUT-1:0] == $past(err_r))
    else $error("error byte read wrong");
  commit_a: assert property (s_check and (ch_r == '0 && inband_c && conv_c[0]) // R1
    |=> out_r[0] == $past(val_r[15:0]))
    else $error("converted value not applied");
endmodule : aoc_ctrl
`default_nettype wire

// *** verif/aoc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host model: apb master standing in for the controller cpu
module aoc_host
  import aoc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end

  // ============================================================
  // one transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk_sys);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk_sys);
    o_penable <= 1'b1;
    @(posedge i_clk_sys);
    while (i_pready !== 1'b1) @(posedge i_clk_sys);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer

  // ============================================================
  // batch enable word: upper byte always zero, eight outputs at most
  task automatic conv_word(input logic [7:0] m);
    logic [31:0] q;
    logic e;
    xfer(1'b1, A_CONV, {24'h00_0000, m}, q, e);
  endtask : conv_word
endmodule : aoc_host
`default_nettype wire

// *** verif/aoc_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module aoc_ctrl_tb;
  import aoc_pkg::*;
  localparam int NO = 8;
  localparam int CL = 60;
  localparam int CS = 20;
  // a full round robin over all outputs, plus scaling latency
  localparam int ROUND = 8 * CL + 60;
  localparam int CLEAR_LVL = -(FS_LONG / BAND_DIV);
  localparam int MAXV = FS_LONG + FS_LONG / BAND_DIV;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel, pen, pwr, rdy, serr, cfg_err, e;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [NO*16-1:0] code;
  logic [NO-1:0] act, sv_err;
  int n_mismatch = 0;
  int cmp_count = 0;
  int sv[4] = '{4200, 4201, -200, -201};
  logic [31:0] ctl[3] = '{32'h0000_0003, 32'h0000_0005, 32'h0000_0001};
  logic [31:0] cnv[3] = '{32'h0000_000F, 32'h0000_000F, 32'h0000_0000};

  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  aoc_host host (.i_clk_sys(i_clk_sys), .i_prdata(rdata), .i_pready(rdy), .i_pslverr(serr),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wdata));

  aoc_ctrl #(.N_OUT(NO), .CYC_LONG(CL), .CYC_SHORT(CS)) dut (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy), .o_pslverr(serr),
    .o_out_code(code), .o_conv_active(act), .o_setvalue_err(sv_err),
    .o_config_err(cfg_err));

  // ============================================================
  // compare and access helpers
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_code(input int k, input int exp);
    cmp_count++;
    if (code[16*k+:16] !== 16'(exp)) begin
      n_mismatch++;
      $display("unexpected at %0t: output %0d code %h, wanted %0d", $time, k,
               code[16*k+:16], exp);
    end
  endtask : chk_code

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk_reg(q, exp);
  endtask : rd

  // outputs are sampled on the falling edge, away from register updates
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : wait_cyc

  task automatic restart(input logic [7:0] en);
    wr(A_RESTART, 32'h0000_0001);
    host.conv_word(en);
    wait_cyc(ROUND);
  endtask : restart

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // ============================================================
  // watchdog: the sequence needs roughly 7200 cycles
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    n_mismatch++;
    $display("unexpected at %0t: run did not complete", $time);
    give_verdict;
  end

  // ============================================================
  // main sequence
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(A_USE, 32'h0000_00FF);
    rd(A_RES, {24'h00_0000, RES_LONG});
    rd(A_CONV, 32'h0000_0000);
    wait_cyc(2);
    chk_code(0, CLEAR_LVL);
    host.xfer(1'b0, 8'h80, 32'h0000_0000, q, e);
    chk_reg({31'h0, e}, 32'h0000_0001);
    wr(A_SV, 32'(1000));
    wr(A_CTRL, 32'h0000_0001);
    host.conv_word(8'h01);
    wait_cyc(ROUND);
    chk_code(0, 1000);
    chk_code(1, CLEAR_LVL);
    chk_reg({31'h0, act[0]}, 32'h0000_0001);
    // band edges: odd entries lie just outside
    foreach (sv[i]) begin
      wr(A_SV, 32'(sv[i]));
      wait_cyc(ROUND);
      chk_code(0, (i % 2) ? CLEAR_LVL : sv[i]);
      chk_reg({31'h0, sv_err[0]}, 32'(i % 2));
      rd(A_ERR, 32'(i % 2));
    end
    // outputs 0 and 2 max, output 1 hold, output 3 bipolar clear
    wr(A_STOP, 32'h0000_0026);
    wr(A_BIP, 32'h0000_0008);
    for (int k = 0; k < 4; k++) wr(A_SV + 8'(4 * k), 32'(k == 0 ? 100 : 1234));
    restart(8'h0F);
    chk_code(3, 1234);
    wr(A_STOP, 32'h0000_0000);
    // fault, foreign adjustment, cleared enables
    for (int c = 0; c < 3; c++) begin
      wr(A_CTRL, ctl[c]);
      wr(A_CONV, cnv[c]);
      wait_cyc(4);
      chk_code(1, 1234);
      chk_code(2, MAXV);
      chk_code(3, 0);
      chk_code(0, (c == 1) ? 100 : MAXV);
      chk_reg({31'h0, act[0]}, 32'(c == 1));
      wr(A_CTRL, 32'h0000_0001);
      wr(A_CONV, 32'h0000_000F);
      wait_cyc(ROUND);
    end
    wr(A_CTRL, 32'h0000_0000);
    rd(A_CONV, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0001);
    // scaling: output 0 forward 0..10000, output 1 reverse
    wr(A_SCL, 32'h2710_0000);
    wr(A_SCL + 8'h04, 32'h0000_2710);
    wr(A_BIP, 32'h0000_0000);
    wr(A_SV, 32'(5002));
    wr(A_SV + 8'h04, 32'(2500));
    restart(8'h03);
    chk_code(0, 2001);
    chk_code(1, 3000);
    wr(A_RES, {24'h00_0000, RES_SHORT});
    restart(8'h03);
    chk_code(0, 5002);
    wr(A_RES, {24'h00_0000, RES_LONG});
    wr(A_SCL, 32'h0005_0005);
    restart(8'h03);
    chk_reg({31'h0, cfg_err}, 32'h0000_0001);
    chk_code(0, CLEAR_LVL);
    wr(A_SCL, 32'h0000_0000);
    wr(A_SCL + 8'h04, 32'h0000_0000);
    wr(A_USE, 32'h0000_006F);
    wr(A_SV, 32'(3000));
    wr(A_SV + 8'h10, 32'(2000));
    restart(8'h13);
    chk_code(0, 3000);
    chk_code(4, 0);
    chk_code(7, 0);
    give_verdict;
  end
endmodule : aoc_ctrl_tb
`default_nettype wire
